/* src/vdn_pkg.sv */
package vdn_pkg;
    localparam int ADDR_W = 9;
    localparam int DIM_W = 13;
    localparam int STR_W = 3;
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 9'h004;
    localparam logic [ADDR_W-1:0] OFS_ERROR = 9'h008;
    localparam logic [ADDR_W-1:0] OFS_MASK = 9'h00C;
    localparam logic [ADDR_W-1:0] OFS_REVISION = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_FRAMES = 9'h014;
    localparam logic [ADDR_W-1:0] OFS_LINES = 9'h018;
    localparam logic [ADDR_W-1:0] OFS_PIXELS = 9'h01C;
    localparam logic [ADDR_W-1:0] OFS_SIZE = 9'h020;
    localparam logic [ADDR_W-1:0] OFS_STRENGTH = 9'h100;
    // field positions
    localparam int CTRL_COMMIT = 1;
    localparam int ST_W = 17;
    localparam int ST_BEGUN = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAULT = 16;
    localparam int ERR_W = 4;
    localparam int ERR_SHORT_LINE = 0;
    localparam int ERR_LONG_LINE = 1;
    localparam int ERR_SHORT_FRAME = 2;
    localparam int ERR_LONG_FRAME = 3;
    localparam int SIZE_PIX_LSB = 0;
    localparam int SIZE_LIN_LSB = 16;
    localparam logic [STR_W-1:0] STR_MAX = 3'h4;
    localparam int EV_W = 9;
    localparam int EV_BEGIN = 0;
    localparam int EV_DONE = 1;
    localparam int EV_PIX_TC = 2;
    localparam int EV_LINE_TC = 3;
    localparam int EV_FAULT = 4;
    localparam int EV_SHORT_LINE = 5;
    localparam int EV_LONG_LINE = 6;
    localparam int EV_SHORT_FRAME = 7;
    localparam int EV_LONG_FRAME = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // values after reset
    localparam logic [DIM_W-1:0] RST_PIXELS = 13'h0780;
    localparam logic [DIM_W-1:0] RST_LINES = 13'h0438;
    localparam logic [STR_W-1:0] RST_STRENGTH = 3'h2;
    // arbitrary revision value
    localparam logic [31:0] RST_REVISION = 32'h0001_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } vdn_lite_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } vdn_lite_rsp_t;

    typedef struct packed {
        logic tvalid;
        logic tuser;
        logic tlast;
    } vdn_stream_t;

    typedef struct packed {
        logic [DIM_W-1:0] lines;
        logic [DIM_W-1:0] pixels;
    } vdn_dims_t;

    typedef struct packed {
        vdn_lite_rsp_t rsp;
        logic tready;
        logic irq;
        logic [EV_W-1:0] evt;
        logic [ST_W-1:0] status;
        logic [ERR_W-1:0] errs;
        logic [ST_W-1:0] mask;
        logic commit;
        vdn_dims_t shadow;
        vdn_dims_t work;
        logic [STR_W-1:0] shadow_str;
        logic [STR_W-1:0] work_str;
        logic [DIM_W-1:0] pix_cnt;
        logic [DIM_W-1:0] line_cnt;
        logic seen_sof;
        logic [31:0] frames;
        logic [31:0] lines;
        logic [31:0] pixels;
    } vdn_state_t;
endpackage : vdn_pkg

/* src/vdn_status_regs.sv */
// What this block does
// - status flags stay set after their event until software clears them
// - writing one clears only that status flag; zero leaves it alone
// - status bit 0 sets when a new frame starts on the input stream
// - status bit 1 sets when a frame finishes
// - status bit 16 sets on any framing error
// - error flags and the summary flag stay latched until cleared
// - writing one to an error bit clears only that error flag
// - error bit 0 sets when a line ends short of the programmed width
// - error bit 1 sets when a line runs past the programmed width
// - error bit 2 sets when a frame starts before enough lines arrived
// - error bit 3 sets when lines exceed the programmed height
// - interrupt is OR of status flags ANDed with mask bits
// - interrupt is a level held while any enabled flag is set
// - read-only frame count at 0x0014 since reset
// - read-only line count at 0x0018 since reset
// - read-only pixel count at 0x001C since reset
// - frame size: pixels per line bits 12:0, lines bits 28:16
// - smoothing level accepts 0..4; 0 bypasses, 4 strongest
// - framing errors and frame events detected regardless of register use
// - nine-bit event vector in the documented bit order
// - event vector bits are unlatched, high only while the event lasts
// - frame size and smoothing level commit to working copy at frame end
`timescale 1ns/1ns
`default_nettype none
module vdn_status_regs
    import vdn_pkg::*;
#(
    parameter logic [DIM_W-1:0] DEF_PIXELS = RST_PIXELS,
    parameter logic [DIM_W-1:0] DEF_LINES = RST_LINES,
    parameter logic [STR_W-1:0] DEF_STRENGTH = RST_STRENGTH,
    parameter logic [31:0] REVISION_ID = RST_REVISION
)
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // register slave
    input wire vdn_lite_req_t lite_req_in,
    output vdn_lite_rsp_t lite_rsp_out,
    // video stream tap
    input wire vdn_stream_t stream_in,
    output logic stream_tready_out,
    // event outputs
    output logic irq_out,
    output logic [EV_W-1:0] parallel_event_vector_out,
    // working settings for the filter datapath
    output vdn_dims_t work_dims_out,
    output logic [STR_W-1:0] smoothing_level_out
);

    vdn_state_t s_q;
    vdn_state_t s_d;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CONTROL, OFS_STATUS, OFS_ERROR, OFS_MASK, OFS_REVISION,
            OFS_FRAMES, OFS_LINES, OFS_PIXELS, OFS_SIZE, OFS_STRENGTH:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : addr_hit

    function automatic logic [DIM_W-1:0] sat_dim(input logic [DIM_W:0] v);
        return v[DIM_W] ? {DIM_W{1'b1}} : v[DIM_W-1:0];
    endfunction : sat_dim

    // bus handshakes
    logic wr_go;
    logic ar_go;
    logic [31:0] wmask;
    assign wr_go = s_q.rsp.awready && lite_req_in.awvalid && lite_req_in.wvalid;
    assign ar_go = s_q.rsp.arready && lite_req_in.arvalid;
    assign wmask = {{8{lite_req_in.wstrb[3]}}, {8{lite_req_in.wstrb[2]}},
                    {8{lite_req_in.wstrb[1]}}, {8{lite_req_in.wstrb[0]}}};

    // stream framing; it runs whether or not software ever touches the registers
    logic beat;
    logic sof;
    logic eol;
    logic [DIM_W-1:0] pos;
    logic [DIM_W:0] pos1;
    logic [DIM_W-1:0] lcur;
    logic [DIM_W:0] l1;
    logic short_line;
    logic long_line;
    logic short_frame;
    logic long_frame;
    logic pix_tc;
    logic frame_done;
    logic slave_err;
    assign beat = stream_in.tvalid && s_q.tready;
    assign sof = beat && stream_in.tuser;
    assign eol = beat && stream_in.tlast;
    assign pos = stream_in.tuser ? '0 : s_q.pix_cnt;
    assign pos1 = {1'b0, pos} + {{DIM_W{1'b0}}, 1'b1};
    assign lcur = stream_in.tuser ? '0 : s_q.line_cnt;
    assign l1 = {1'b0, lcur} + {{DIM_W{1'b0}}, 1'b1};
    assign short_line = eol && (pos1 < {1'b0, s_q.work.pixels});
    assign long_line = beat && (pos1 > {1'b0, s_q.work.pixels});
    // the first frame after reset has no earlier frame to be short against
    assign short_frame = sof && s_q.seen_sof && (s_q.line_cnt < s_q.work.lines);
    assign long_frame = eol && (l1 > {1'b0, s_q.work.lines});
    assign pix_tc = beat && (pos1 == {1'b0, s_q.work.pixels});
    assign frame_done = eol && (l1 == {1'b0, s_q.work.lines});
    assign slave_err = short_line || long_line || short_frame || long_frame;

    // sticky flag sets and software clears
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    logic [ERR_W-1:0] er_set;
    logic [ERR_W-1:0] er_clr;
    always_comb
    begin
        st_set = '0;
        st_set[ST_BEGUN] = sof;
        st_set[ST_DONE] = frame_done;
        st_set[ST_FAULT] = slave_err;
        er_set = '0;
        er_set[ERR_SHORT_LINE] = short_line;
        er_set[ERR_LONG_LINE] = long_line;
        er_set[ERR_SHORT_FRAME] = short_frame;
        er_set[ERR_LONG_FRAME] = long_frame;
    end
    assign st_clr = (wr_go && lite_req_in.awaddr == OFS_STATUS) ?
                    (lite_req_in.wdata[ST_W-1:0] & wmask[ST_W-1:0]) : '0;
    assign er_clr = (wr_go && lite_req_in.awaddr == OFS_ERROR) ?
                    (lite_req_in.wdata[ERR_W-1:0] & wmask[ERR_W-1:0]) : '0;

    // register read view
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = '0;
        case (lite_req_in.araddr)
            OFS_CONTROL: rd_val[CTRL_COMMIT] = s_q.commit;
            OFS_STATUS: rd_val[ST_W-1:0] = s_q.status;
            OFS_ERROR: rd_val[ERR_W-1:0] = s_q.errs;
            OFS_MASK: rd_val[ST_W-1:0] = s_q.mask;
            OFS_REVISION: rd_val = REVISION_ID;
            OFS_FRAMES: rd_val = s_q.frames;
            OFS_LINES: rd_val = s_q.lines;
            OFS_PIXELS: rd_val = s_q.pixels;
            OFS_SIZE:
            begin
                rd_val[SIZE_PIX_LSB +: DIM_W] = s_q.shadow.pixels;
                rd_val[SIZE_LIN_LSB +: DIM_W] = s_q.shadow.lines;
            end
            OFS_STRENGTH: rd_val[STR_W-1:0] = s_q.shadow_str;
            default: rd_val = '0;
        endcase
    end

    logic [31:0] wtmp;
    always_comb
    begin
        wtmp = '0;
        s_d = s_q;
        s_d.tready = 1'b1;
        // write channel: address and data are taken together, one at a time
        s_d.rsp.awready = !s_q.rsp.awready && !s_q.rsp.bvalid &&
                          lite_req_in.awvalid && lite_req_in.wvalid;
        s_d.rsp.wready = s_d.rsp.awready;
        if (s_q.rsp.bvalid && lite_req_in.bready)
        begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = addr_hit(lite_req_in.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (lite_req_in.awaddr)
                OFS_CONTROL:
                begin
                    wtmp = merge({30'h0, s_q.commit, 1'b0}, lite_req_in.wdata,
                                 lite_req_in.wstrb);
                    s_d.commit = wtmp[CTRL_COMMIT];
                end
                OFS_MASK:
                begin
                    wtmp = merge({15'h0, s_q.mask}, lite_req_in.wdata, lite_req_in.wstrb);
                    s_d.mask = wtmp[ST_W-1:0];
                end
                OFS_SIZE:
                begin
                    wtmp = merge({3'h0, s_q.shadow.lines, 3'h0, s_q.shadow.pixels},
                                 lite_req_in.wdata, lite_req_in.wstrb);
                    s_d.shadow.pixels = wtmp[SIZE_PIX_LSB +: DIM_W];
                    s_d.shadow.lines = wtmp[SIZE_LIN_LSB +: DIM_W];
                end
                OFS_STRENGTH:
                begin
                    wtmp = merge({29'h0, s_q.shadow_str}, lite_req_in.wdata,
                                 lite_req_in.wstrb);
                    // out-of-range levels are dropped so the filter never sees them
                    if (wtmp[31:STR_W] == 29'h0 && wtmp[STR_W-1:0] <= STR_MAX)
                    begin
                        s_d.shadow_str = wtmp[STR_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        // read channel
        s_d.rsp.arready = !s_q.rsp.arready && !s_q.rsp.rvalid && lite_req_in.arvalid;
        if (s_q.rsp.rvalid && lite_req_in.rready)
        begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (ar_go)
        begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = rd_val;
            s_d.rsp.rresp = addr_hit(lite_req_in.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        // a set in the same cycle as its clear wins
        s_d.status = (s_q.status & ~st_clr) | st_set;
        s_d.errs = (s_q.errs & ~er_clr) | er_set;
        s_d.irq = |(s_d.status & s_d.mask);
        // unlatched copies of each event, one cycle per offending beat
        s_d.evt[EV_BEGIN] = sof;
        s_d.evt[EV_DONE] = frame_done;
        s_d.evt[EV_PIX_TC] = pix_tc;
        s_d.evt[EV_LINE_TC] = frame_done;
        s_d.evt[EV_FAULT] = slave_err;
        s_d.evt[EV_SHORT_LINE] = short_line;
        s_d.evt[EV_LONG_LINE] = long_line;
        s_d.evt[EV_SHORT_FRAME] = short_frame;
        s_d.evt[EV_LONG_FRAME] = long_frame;
        // position counters saturate so a runaway line cannot alias to valid
        if (eol)
        begin
            s_d.pix_cnt = '0;
            s_d.line_cnt = sat_dim(l1);
        end
        else if (beat)
        begin
            s_d.pix_cnt = sat_dim(pos1);
            s_d.line_cnt = lcur;
        end
        if (sof)
        begin
            s_d.seen_sof = 1'b1;
        end
        // throughput counters wrap naturally at 32 bits
        if (frame_done)
        begin
            s_d.frames = s_q.frames + 32'h1;
        end
        if (eol)
        begin
            s_d.lines = s_q.lines + 32'h1;
        end
        if (beat)
        begin
            s_d.pixels = s_q.pixels + 32'h1;
        end
        // settings change only at a frame boundary to avoid tearing
        if (frame_done && s_q.commit)
        begin
            s_d.work = s_q.shadow;
            s_d.work_str = s_q.shadow_str;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            s_q <= '0;
            s_q.shadow.pixels <= DEF_PIXELS;
            s_q.shadow.lines <= DEF_LINES;
            s_q.work.pixels <= DEF_PIXELS;
            s_q.work.lines <= DEF_LINES;
            s_q.shadow_str <= DEF_STRENGTH;
            s_q.work_str <= DEF_STRENGTH;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign lite_rsp_out = s_q.rsp;
    assign stream_tready_out = s_q.tready;
    assign irq_out = s_q.irq;
    assign parallel_event_vector_out = s_q.evt;
    assign work_dims_out = s_q.work;
    assign smoothing_level_out = s_q.work_str;

    a_sticky_begun: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        s_q.status[ST_BEGUN] && !st_clr[ST_BEGUN] |=> s_q.status[ST_BEGUN])
        else $error("begun flag dropped without a clear");
    a_w1c_done: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        st_clr[ST_BEGUN] && !sof && !st_clr[ST_DONE] && s_q.status[ST_DONE]
        |=> !s_q.status[ST_BEGUN] && s_q.status[ST_DONE])
        else $error("status clear hit the wrong bit");
    a_begin_sets: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        sof |=> s_q.status[ST_BEGUN] && s_q.evt[EV_BEGIN])
        else $error("frame start not flagged");
    a_done_sets: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        frame_done |=> s_q.status[ST_DONE] && $past(s_q.frames) + 32'h1 == s_q.frames)
        else $error("frame done not flagged or counted");
    a_fault_summary: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        slave_err |=> s_q.status[ST_FAULT] && (s_q.errs != '0))
        else $error("framing error without summary flag");
    a_err_sticky: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        s_q.errs[ERR_LONG_LINE] && !er_clr[ERR_LONG_LINE] |=> s_q.errs[ERR_LONG_LINE])
        else $error("error flag dropped without a clear");
    a_err_w1c: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        er_clr == 4'h1 && !short_line && s_q.errs[ERR_SHORT_FRAME]
        |=> !s_q.errs[ERR_SHORT_LINE] && s_q.errs[ERR_SHORT_FRAME])
        else $error("error clear hit the wrong bit");
    a_short_line: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        eol && (pos1 < {1'b0, s_q.work.pixels}) |=> s_q.errs[ERR_SHORT_LINE])
        else $error("short line missed");
    a_long_line: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        beat && pos == s_q.work.pixels |=> s_q.errs[ERR_LONG_LINE])
        else $error("long line missed");
    a_frame_errs: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        short_frame || long_frame |=> s_q.errs[ERR_SHORT_FRAME] || s_q.errs[ERR_LONG_FRAME])
        else $error("frame length error missed");
    a_irq_level: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        irq_out == |(s_q.status & s_q.mask))
        else $error("interrupt level disagrees with masked flags");
    a_pixel_wrap: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        beat |=> s_q.pixels == $past(s_q.pixels) + 32'h1)
        else $error("pixel count did not wrap");
    a_evt_unlatched: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !slave_err |=> !s_q.evt[EV_FAULT])
        else $error("event vector held past its event");
    a_commit_frame: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !(frame_done && s_q.commit) |=> $stable(s_q.work) && $stable(s_q.work_str))
        else $error("working settings changed outside a committed frame end");
    a_level_range: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        wr_go && lite_req_in.awaddr == OFS_STRENGTH && lite_req_in.wstrb[0]
        && lite_req_in.wdata[STR_W-1:0] > STR_MAX |=> $stable(s_q.shadow_str))
        else $error("out-of-range smoothing level accepted");
    a_line_count: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        eol |=> s_q.lines == $past(s_q.lines) + 32'h1)
        else $error("line count did not advance");
    a_evt_order: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        frame_done |=> s_q.evt[EV_DONE] && s_q.evt[EV_LINE_TC])
        else $error("frame end missing from event vector");
    a_evt_fault: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        slave_err |=> s_q.evt[EV_FAULT])
        else $error("framing error missing from event vector");
    a_short_frame: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        sof && s_q.seen_sof && (s_q.line_cnt < s_q.work.lines) |=> s_q.errs[ERR_SHORT_FRAME])
        else $error("short frame missed");
    a_long_frame: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        eol && (l1 > {1'b0, s_q.work.lines}) |=> s_q.errs[ERR_LONG_FRAME])
        else $error("long frame missed");
    a_size_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        wr_go && lite_req_in.awaddr == OFS_SIZE && lite_req_in.wstrb == 4'hF
        |=> s_q.shadow.pixels == $past(lite_req_in.wdata[SIZE_PIX_LSB +: DIM_W])
        && s_q.shadow.lines == $past(lite_req_in.wdata[SIZE_LIN_LSB +: DIM_W]))
        else $error("frame size write landed in the wrong field");

endmodule : vdn_status_regs
`default_nettype wire

/* tb/vdn_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
module vdn_src_model
    import vdn_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // frame request
    input wire logic go_in,
    input wire logic [DIM_W-1:0] pix_in,
    input wire logic [DIM_W-1:0] lin_in,
    output logic busy_out,
    // stream
    input wire logic ready_in,
    output vdn_stream_t strm_out
);
    logic [DIM_W-1:0] x_q;
    logic [DIM_W-1:0] y_q;
    logic idle_q;

    // markers toggle between frames so a stale level never looks valid
    assign strm_out.tvalid = busy_out;
    assign strm_out.tuser = busy_out ? (x_q == '0 && y_q == '0) : idle_q;
    assign strm_out.tlast = busy_out ? (x_q + 13'h1 == pix_in) : ~idle_q;

    always @(posedge clk_in)
    begin
        idle_q <= ~idle_q;
        if (!rstn_in)
        begin
            busy_out <= 1'b0;
            idle_q <= 1'b0;
        end
        else if (go_in && !busy_out)
        begin
            busy_out <= 1'b1;
            x_q <= '0;
            y_q <= '0;
        end
        else if (busy_out && ready_in)
        begin
            if (x_q + 13'h1 < pix_in)
                x_q <= x_q + 13'h1;
            else
            begin
                x_q <= '0;
                y_q <= y_q + 13'h1;
                if (y_q + 13'h1 >= lin_in)
                    busy_out <= 1'b0;
            end
        end
    end
endmodule : vdn_src_model
`default_nettype wire

/* tb/vdn_status_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module vdn_status_regs_tb
    import vdn_pkg::*;
;
    typedef struct {logic [ADDR_W-1:0] a; logic [31:0] d; logic [1:0] r;} vdn_row_t;
    // small frame sizes keep each frame short
    localparam logic [DIM_W-1:0] PIX = 13'h0020;
    localparam logic [DIM_W-1:0] LIN = 13'h0020;
    localparam logic [31:0] REV = 32'h0000_0ABC; // arbitrary value
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    vdn_lite_req_t req = '0;
    vdn_lite_rsp_t rsp;
    vdn_stream_t strm;
    logic tready, irq, go = 1'b0, busy;
    logic [EV_W-1:0] evt, ev_seen = '0;
    logic [DIM_W-1:0] pix = PIX, lin = LIN;
    logic [STR_W-1:0] str;
    vdn_dims_t dims;
    int err_count = 0, checked = 0;
    vdn_row_t rows[10] = '{'{OFS_STATUS, 0, RESP_OKAY}, '{OFS_ERROR, 0, RESP_OKAY},
        '{OFS_MASK, 0, RESP_OKAY}, '{OFS_REVISION, REV, RESP_OKAY},
        '{OFS_FRAMES, 0, RESP_OKAY}, '{OFS_LINES, 0, RESP_OKAY}, '{OFS_PIXELS, 0, RESP_OKAY},
        '{OFS_SIZE, {3'h0, LIN, 3'h0, PIX}, RESP_OKAY},
        '{OFS_STRENGTH, 32'h2, RESP_OKAY}, '{9'h024, 0, RESP_SLVERR}};

    vdn_status_regs #(.DEF_PIXELS(PIX), .DEF_LINES(LIN), .DEF_STRENGTH(3'h2),
        .REVISION_ID(REV)) i_dut (.core_clk_in(core_clk), .rstn_in(rstn),
        .lite_req_in(req), .lite_rsp_out(rsp), .stream_in(strm),
        .stream_tready_out(tready), .irq_out(irq), .parallel_event_vector_out(evt),
        .work_dims_out(dims), .smoothing_level_out(str));
    vdn_src_model i_src (.clk_in(core_clk), .rstn_in(rstn), .go_in(go), .pix_in(pix),
        .lin_in(lin), .busy_out(busy), .ready_in(tready), .strm_out(strm));

    initial forever #10 core_clk = ~core_clk;
    // cleared in reset so an unknown vector before the first edge cannot stick
    always @(posedge core_clk) ev_seen <= rstn ? (ev_seen | evt) : '0;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do @(posedge core_clk); while (rsp.awready !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(posedge core_clk); while (rsp.bvalid !== 1'b1);
    endtask : wr

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge core_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge core_clk); while (rsp.rvalid !== 1'b1);
        check(rsp.rdata, d);
        check({30'h0, rsp.rresp}, {30'h0, r});
    endtask : rdc

    task automatic frame(input logic [DIM_W-1:0] p, input logic [DIM_W-1:0] l);
        @(posedge core_clk);
        pix <= p;
        lin <= l;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        // busy only rises at the edge after go, so wait at least one more edge
        do @(posedge core_clk); while (busy !== 1'b0);
        repeat (2) @(posedge core_clk);
    endtask : frame

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        foreach (rows[i])
            rdc(rows[i].a, rows[i].d, rows[i].r);
        frame(PIX, LIN);
        rdc(OFS_STATUS, 32'h3, RESP_OKAY);
        rdc(OFS_FRAMES, 32'h1, RESP_OKAY);
        rdc(OFS_LINES, 32'h20, RESP_OKAY);
        wr(OFS_PIXELS, 32'h0);
        rdc(OFS_PIXELS, 32'h400, RESP_OKAY);
        check(ev_seen, 9'h00F);
        check(irq, 1'b0);
        wr(OFS_MASK, 32'h2);
        @(posedge core_clk);
        check(irq, 1'b1);
        wr(OFS_STATUS, 32'h1);
        rdc(OFS_STATUS, 32'h2, RESP_OKAY);
        check(irq, 1'b1);
        wr(OFS_STATUS, 32'h2);
        rdc(OFS_STATUS, 32'h0, RESP_OKAY);
        check(irq, 1'b0);
        // short line, long line, cut frame, then overlong frame
        frame(PIX - 13'h1, LIN);
        frame(PIX + 13'h1, LIN);
        frame(PIX, LIN - 13'h1);
        frame(PIX, LIN);
        frame(PIX, LIN + 13'h1);
        check(evt, 9'h000);
        check(ev_seen, 9'h1FF);
        rdc(OFS_ERROR, 32'hF, RESP_OKAY);
        rdc(OFS_STATUS, 32'h1_0003, RESP_OKAY);
        wr(OFS_MASK, 32'h1_0000);
        @(posedge core_clk);
        check(irq, 1'b1);
        wr(OFS_ERROR, 32'h1);
        rdc(OFS_ERROR, 32'hE, RESP_OKAY);
        wr(OFS_SIZE, {3'h0, LIN, 3'h0, 13'h0028});
        wr(OFS_STRENGTH, 32'h0);
        rdc(OFS_STRENGTH, 32'h0, RESP_OKAY);
        wr(OFS_STRENGTH, 32'h5);
        rdc(OFS_STRENGTH, 32'h0, RESP_OKAY);
        wr(OFS_STRENGTH, 32'h4);
        rdc(OFS_SIZE, {3'h0, LIN, 3'h0, 13'h0028}, RESP_OKAY);
        check({19'h0, dims.pixels}, {19'h0, PIX});
        check({29'h0, str}, 32'h2);
        wr(OFS_CONTROL, 32'h2);
        frame(PIX, LIN);
        check({19'h0, dims.pixels}, 32'h28);
        check({29'h0, str}, 32'h4);
        // reset in mid-run clears tallies and flags and restores the default working settings
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        rdc(OFS_FRAMES, 32'h0, RESP_OKAY);
        rdc(OFS_STATUS, 32'h0, RESP_OKAY);
        check(irq, 1'b0);
        check({19'h0, dims.pixels}, {19'h0, PIX});
        check({29'h0, str}, 32'h2);
        print_verdict();
    end
endmodule : vdn_status_regs_tb
`default_nettype wire
